// ### src/ahs_pkg.sv
// constants, register map and state type of the axis homing sequencer
package ahs_pkg;
    localparam int SPD_W = 16;
    localparam int RAMP_W = 16;
    localparam int ACC_W = 16;
    localparam int DIV_W = 16;
    localparam int MAX_AXES = 8;
    // clock and interpolation tick
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_DIV_DFLT = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // speed change per ramp step
    localparam logic [SPD_W-1:0] SPD_STEP = 16'h0010;
    // byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DIR = 8'h04;
    localparam logic [7:0] OFF_START = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_CREEP = 8'h10;
    localparam logic [7:0] OFF_RAMP_A = 8'h14;
    localparam logic [7:0] OFF_RAMP_S = 8'h18;
    localparam logic [2:0] WIN_FAST = 3'h1;
    localparam logic [2:0] WIN_CROSS = 3'h2;
    // control fields
    localparam int CTRL_BEFORE = 0;
    localparam int CTRL_MARKER = 1;
    localparam int CTRL_TYPE_B = 2;
    localparam int CTRL_G28_NODOG = 3;
    // start register fields
    localparam int START_MAN = 0;
    localparam int START_G28 = 8;
    localparam int START_ABORT = 16;
    // status fields
    localparam int STAT_DONE = 0;
    localparam int STAT_BUSY = 8;
    // reset values
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [SPD_W-1:0] FAST_RST = 16'h0fa0;
    localparam logic [SPD_W-1:0] CROSS_RST = 16'h01f4;
    localparam logic [SPD_W-1:0] CREEP_RST = 16'h0028;
    localparam logic [RAMP_W-1:0] RAMP_RST = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FAST,
        ST_CROSS,
        ST_CREEP,
        ST_DEC0,
        ST_REV,
        ST_DONE
    } ahs_state_t;
endpackage : ahs_pkg

// ### src/ahs_sequencer.sv
// per-axis machine-zero homing sequencer with apb register access
//
// Notes on behaviour
// - one setting selects zero taken after the switch or before it
// - one setting selects homing on the marker pulse or without marker
// - without marker a setting chooses type A or type B sequence
// - each axis moves toward home in its own direction bit
// - approach runs at the per-axis fast approach speed
// - approach ramping uses one shared approach ramp time
// - each axis has its own switch input, high while on the dog
// - type B after switch: on dog release drop at once to creep speed
// - type B after switch: stop when switch asserts again, homing finished
// - type B before switch: stop on dog, reverse at creep speed
// - after switch: on dog the axis slows to its switch-crossing speed
// - slowdown to crossing speed uses one shared slowdown ramp time
// - type A: stop at once at the terminal point, that is zero
// - type A before switch: stop on dog, reverse at crossing speed
// - after leaving the dog continue at the final low speed
// - marker homing seeks marker at creep speed, halts on capture
// - home-done raised once the axis stops at machine zero
// - program return runs the same dog sequence when its bit is 0
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module ahs_sequencer
    import ahs_pkg::*;
#(
    parameter int N_AXES = 5,
    parameter int TICK_DIV = ahs_pkg::TICK_DIV_DFLT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_AXES-1:0] home_decel_switch_in,
    input wire logic [N_AXES-1:0] marker_in,
    output logic [N_AXES-1:0] step_pulse,
    output logic [N_AXES-1:0] step_dir,
    output logic [N_AXES-1:0] home_done,
    output logic [N_AXES-1:0] homing_busy
);
    import ahs_pkg::*;

    if (N_AXES < 1 || N_AXES > MAX_AXES) begin : g_bad_axes
        $error("N_AXES out of range");
    end
    if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_div
        $error("TICK_DIV out of range");
    end

    function automatic logic [SPD_W-1:0] ramp_to(input logic [SPD_W-1:0] cur,
                                                   input logic [SPD_W-1:0] tgt);
        logic [SPD_W-1:0] gap;
        gap = (cur < tgt) ? tgt - cur : cur - tgt;
        if (gap <= SPD_STEP) begin
            ramp_to = tgt;
        end else if (cur < tgt) begin
            ramp_to = cur + SPD_STEP;
        end else begin
            ramp_to = cur - SPD_STEP;
        end
    endfunction : ramp_to

    // ==========================================================
    // apb decode
    // ==========================================================
    logic [3:0] ctrl_q;
    logic [N_AXES-1:0] dir_q;
    logic [SPD_W-1:0] creep_q;
    logic [RAMP_W-1:0] ramp_a_q;
    logic [RAMP_W-1:0] ramp_s_q;
    logic [SPD_W-1:0] fast_q [N_AXES];
    logic [SPD_W-1:0] cross_q [N_AXES];
    logic [31:0] prdata_q;
    logic [N_AXES-1:0] done_v;
    logic [N_AXES-1:0] busy_v;

    wire [7:0] off = paddr[7:0];
    wire [2:0] idx = off[4:2];
    wire in_range = (paddr[11:8] == 4'h0) && (off[1:0] == 2'b00);
    wire idx_ok = ({1'b0, idx} < 4'(N_AXES));
    wire hit_ctrl = in_range && (off == OFF_CTRL);
    wire hit_dir = in_range && (off == OFF_DIR);
    wire hit_start = in_range && (off == OFF_START);
    wire hit_stat = in_range && (off == OFF_STATUS);
    wire hit_creep = in_range && (off == OFF_CREEP);
    wire hit_ra = in_range && (off == OFF_RAMP_A);
    wire hit_rs = in_range && (off == OFF_RAMP_S);
    wire hit_fast = in_range && (off[7:5] == WIN_FAST) && idx_ok;
    wire hit_cross = in_range && (off[7:5] == WIN_CROSS) && idx_ok;
    wire mapped = hit_ctrl | hit_dir | hit_start | hit_stat | hit_creep | hit_ra | hit_rs
                  | hit_fast | hit_cross;
    wire wr_acc = psel & penable & pwrite & mapped;
    wire rd_setup = psel & ~penable & ~pwrite;

    wire sel_before = ctrl_q[CTRL_BEFORE];
    wire sel_marker = ctrl_q[CTRL_MARKER];
    wire sel_type_b = ctrl_q[CTRL_TYPE_B];
    wire g28_nodog = ctrl_q[CTRL_G28_NODOG];

    wire [31:0] rd_mux =
        hit_ctrl ? {28'h0, ctrl_q} :
        hit_dir ? 32'(dir_q) :
        hit_stat ? (32'(done_v) << STAT_DONE) | (32'(busy_v) << STAT_BUSY) :
        hit_creep ? {16'h0, creep_q} :
        hit_ra ? {16'h0, ramp_a_q} :
        hit_rs ? {16'h0, ramp_s_q} :
        hit_fast ? {16'h0, fast_q[idx]} :
        hit_cross ? {16'h0, cross_q[idx]} :
        32'h0;

    // start register: manual, program return and abort pulses
    wire [N_AXES-1:0] man_pls = (wr_acc && hit_start) ? pwdata[START_MAN +: N_AXES] : '0;
    wire [N_AXES-1:0] g28_raw = (wr_acc && hit_start) ? pwdata[START_G28 +: N_AXES] : '0;
    wire [N_AXES-1:0] g28_pls = g28_raw & {N_AXES{~g28_nodog}};
    wire [N_AXES-1:0] abort_pls = (wr_acc && hit_start) ? pwdata[START_ABORT +: N_AXES] : '0;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (rd_setup) begin
            prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            dir_q <= '0;
            creep_q <= CREEP_RST;
            ramp_a_q <= RAMP_RST;
            ramp_s_q <= RAMP_RST;
            for (int i = 0; i < N_AXES; i++) begin
                fast_q[i] <= FAST_RST;
                cross_q[i] <= CROSS_RST;
            end
        end else if (wr_acc) begin
            if (hit_ctrl) begin
                ctrl_q <= pwdata[3:0];
            end
            if (hit_dir) begin
                dir_q <= pwdata[N_AXES-1:0];
            end
            if (hit_creep) begin
                creep_q <= pwdata[SPD_W-1:0];
            end
            if (hit_ra) begin
                ramp_a_q <= pwdata[RAMP_W-1:0];
            end
            if (hit_rs) begin
                ramp_s_q <= pwdata[RAMP_W-1:0];
            end
            if (hit_fast) begin
                fast_q[idx] <= pwdata[SPD_W-1:0];
            end
            if (hit_cross) begin
                cross_q[idx] <= pwdata[SPD_W-1:0];
            end
        end
    end

    // ==========================================================
    // interpolation tick and input synchronisers
    // ==========================================================
    logic [DIV_W-1:0] div_q;
    logic [N_AXES-1:0] sw_s1;
    logic [N_AXES-1:0] sw_s2;
    logic [N_AXES-1:0] mk_s1;
    logic [N_AXES-1:0] mk_s2;
    logic [N_AXES-1:0] mk_s3;

    wire tick = (div_q == DIV_W'(TICK_DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_s1 <= '0;
            sw_s2 <= '0;
            mk_s1 <= '0;
            mk_s2 <= '0;
            mk_s3 <= '0;
        end else begin
            sw_s1 <= home_decel_switch_in;
            sw_s2 <= sw_s1;
            mk_s1 <= marker_in;
            mk_s2 <= mk_s1;
            mk_s3 <= mk_s2;
        end
    end

    // ==========================================================
    // per-axis sequencer
    // ==========================================================
    for (genvar a = 0; a < N_AXES; a++) begin : g_ax
        ahs_state_t st_q;
        logic [SPD_W-1:0] spd_q;
        logic [RAMP_W-1:0] rc_q;
        logic [ACC_W-1:0] acc_q;
        logic dir_ax_q;
        logic stp_q;
        logic done_q;

        wire on_dog = sw_s2[a];
        wire mk_cap = mk_s2[a] & ~mk_s3[a];
        wire go = man_pls[a] | g28_pls[a];
        wire idle_like = (st_q == ST_IDLE) || (st_q == ST_DONE);
        wire type_a = ~sel_marker & ~sel_type_b;
        wire [RAMP_W-1:0] rt = (st_q == ST_FAST) ? ramp_a_q : ramp_s_q;
        wire [SPD_W-1:0] tgt =
            (st_q == ST_FAST) ? fast_q[a] :
            (st_q == ST_CROSS) ? cross_q[a] :
            (st_q == ST_DEC0) ? '0 :
            spd_q;
        wire ramp_en = tick && (rc_q >= rt);
        wire [ACC_W:0] sum = {1'b0, acc_q} + {1'b0, spd_q};
        wire [SPD_W-1:0] ramped = ramp_to(spd_q, tgt);
        wire seek_hit = sel_marker ? mk_cap : on_dog;
        wire rev_hit = sel_marker ? mk_cap : ~on_dog;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                rc_q <= '0;
            end else if (idle_like) begin
                rc_q <= '0;
            end else if (tick) begin
                rc_q <= ramp_en ? '0 : rc_q + 1'b1;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                st_q <= ST_IDLE;
                spd_q <= '0;
                dir_ax_q <= 1'b0;
                done_q <= 1'b0;
            end else if (abort_pls[a]) begin
                st_q <= ST_IDLE;
                spd_q <= '0;
                done_q <= 1'b0;
            end else if (go && idle_like) begin
                st_q <= ST_FAST;
                spd_q <= '0;
                dir_ax_q <= dir_q[a];
                done_q <= 1'b0;
            end else begin
                unique case (st_q)
                    ST_IDLE, ST_DONE: begin
                        spd_q <= '0;
                    end
                    ST_FAST: begin
                        if (on_dog) begin
                            st_q <= sel_before ? ST_DEC0 : ST_CROSS;
                        end else if (ramp_en) begin
                            spd_q <= ramped;
                        end
                    end
                    ST_CROSS: begin
                        if (!on_dog && type_a) begin
                            st_q <= ST_DONE;
                            spd_q <= '0;
                            done_q <= 1'b1;
                        end else if (!on_dog) begin
                            st_q <= ST_CREEP;
                            spd_q <= creep_q;
                        end else if (ramp_en) begin
                            spd_q <= ramped;
                        end
                    end
                    ST_CREEP: begin
                        if (seek_hit) begin
                            st_q <= ST_DONE;
                            spd_q <= '0;
                            done_q <= 1'b1;
                        end
                    end
                    ST_DEC0: begin
                        if (spd_q == '0) begin
                            st_q <= ST_REV;
                            dir_ax_q <= ~dir_ax_q;
                            spd_q <= type_a ? cross_q[a] : creep_q;
                        end else if (ramp_en) begin
                            spd_q <= ramped;
                        end
                    end
                    ST_REV: begin
                        if (rev_hit) begin
                            st_q <= ST_DONE;
                            spd_q <= '0;
                            done_q <= 1'b1;
                        end
                    end
                endcase
            end
        end

        // pulse train: phase accumulator carry gives one step
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                acc_q <= '0;
                stp_q <= 1'b0;
            end else if (tick && spd_q != '0) begin
                acc_q <= sum[ACC_W-1:0];
                stp_q <= sum[ACC_W];
            end else begin
                stp_q <= 1'b0;
            end
        end

        assign step_pulse[a] = stp_q;
        assign step_dir[a] = dir_ax_q;
        assign home_done[a] = done_q;
        assign done_v[a] = done_q;
        assign busy_v[a] = ~idle_like;
        assign homing_busy[a] = ~idle_like;
    end

endmodule : ahs_sequencer

`default_nettype wire

// ### tb/ahs_axis_model.sv
// axis drive model: step counter, home dogs and one-turn marker
`timescale 1ns/1ps
`default_nettype none
module ahs_axis_model #(
    parameter int N = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic [N-1:0] dir_cfg,
    input wire logic [N-1:0] step_pulse,
    input wire logic [N-1:0] step_dir,
    output logic [N-1:0] dog,
    output logic [N-1:0] marker,
    output logic [7:0] pos [N]
);
    for (genvar i = 0; i < N; i++) begin : g_ax
        // position counts up while moving toward home
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pos[i] <= 8'h00;
            end else if (clr) begin
                pos[i] <= 8'h00;
            end else if (step_pulse[i]) begin
                pos[i] <= (step_dir[i] == dir_cfg[i]) ? pos[i] + 8'h01 : pos[i] - 8'h01;
            end
        end
        // first dog 0x10..0x4f, second dog from 0x60 on
        assign dog[i] = (pos[i] >= 8'h10 && pos[i] < 8'h50) || pos[i] >= 8'h60;
        assign marker[i] = pos[i][2:0] == 3'h0;
    end
endmodule : ahs_axis_model
`default_nettype wire

// ### tb/ahs_sequencer_asserts.sv
// port checker for the axis homing sequencer
`timescale 1ns/1ps
`default_nettype none
module ahs_sequencer_asserts
    import ahs_pkg::*;
#(
    parameter int N_AXES = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [N_AXES-1:0] home_decel_switch_in,
    input wire logic [N_AXES-1:0] marker_in,
    input wire logic [N_AXES-1:0] step_pulse,
    input wire logic [N_AXES-1:0] step_dir,
    input wire logic [N_AXES-1:0] home_done,
    input wire logic [N_AXES-1:0] homing_busy
);
    wire logic wr_start;
    assign wr_start = psel && penable && pwrite && paddr == {4'h0, OFF_START};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_start_seen;
        $past(wr_start) || $past(wr_start, 2);
    endsequence
    a_step_single: assert property ((step_pulse & $past(step_pulse)) == '0)
        else $error("step pulse longer than one cycle");
    a_step_when_busy: assert property ((step_pulse & ~(homing_busy | $past(homing_busy))) == '0)
        else $error("step while axis idle");
    a_no_step_done: assert property ((step_pulse & home_done & $past(home_done)) == '0)
        else $error("step after home reached");
    a_done_idle: assert property ((home_done & homing_busy) == '0)
        else $error("done and busy together");
    a_done_holds: assert property ((($past(home_done) & ~home_done) != '0) |-> s_start_seen)
        else $error("done dropped without start");
    a_busy_from_start: assert property (((homing_busy & ~$past(homing_busy)) != '0) |-> s_start_seen)
        else $error("busy without start");
    a_dir_steady: assert property ((step_dir != $past(step_dir)) |->
        ($past(homing_busy) != '0 || $past(wr_start) || $past(wr_start, 2)))
        else $error("direction changed while idle");
    a_err_unmapped: assert property (psel && penable && paddr[11:8] != 4'h0 |-> pslverr)
        else $error("no error on unmapped access");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access");
endmodule : ahs_sequencer_asserts
bind ahs_sequencer ahs_sequencer_asserts #(.N_AXES(N_AXES)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .marker_in(marker_in),
    .home_decel_switch_in(home_decel_switch_in), .step_pulse(step_pulse),
    .step_dir(step_dir), .home_done(home_done), .homing_busy(homing_busy));
`default_nettype wire

// ### tb/tb.sv
// self-checking testbench for the axis homing sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ahs_pkg::*;
    typedef struct {logic [3:0] ctrl; int ax; logic [4:0] dir; int sh; logic [7:0] ex; logic [7:0] mk;} ahs_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic clr = 1'b0;
    logic [4:0] dir_cfg = 5'h00;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic [4:0] dog, marker, step_pulse, step_dir, home_done, homing_busy;
    logic [7:0] pos [5];
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    ahs_row_t rows [7];
    always #4 pclk = ~pclk;
    ahs_sequencer #(.N_AXES(5), .TICK_DIV(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .home_decel_switch_in(dog), .marker_in(marker),
        .step_pulse(step_pulse), .step_dir(step_dir), .home_done(home_done),
        .homing_busy(homing_busy));
    ahs_axis_model #(.N(5)) u_axis (.pclk(pclk), .presetn(presetn), .clr(clr), .dir_cfg(dir_cfg),
        .step_pulse(step_pulse), .step_dir(step_dir), .dog(dog), .marker(marker), .pos(pos));
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] ex);
        cmp_count++;
        if (seen !== ex) begin
            fail_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, ex);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rc(input logic [11:0] a, input logic [31:0] ex, input logic e);
        apb(1'b0, a, 32'h0);
        chk(rd, ex);
        chk(32'(err), 32'(e));
    endtask : rc
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset
    task automatic cfg();
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 12'h020 + 12'(4 * i), 32'h2000);
            apb(1'b1, 12'h040 + 12'(4 * i), 32'h1000);
        end
        apb(1'b1, {4'h0, OFF_CREEP}, 32'h1000);
    endtask : cfg
    task automatic wait_done(input int ax);
        int n;
        n = 0;
        while (home_done[ax] !== 1'b1 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_done
    initial begin
        rows[0] = '{4'h0, 0, 5'h01, 0, 8'h50, 8'hff};
        rows[1] = '{4'h4, 1, 5'h00, 0, 8'h60, 8'hff};
        rows[2] = '{4'h2, 2, 5'h04, 0, 8'h00, 8'h07};
        rows[3] = '{4'h1, 3, 5'h08, 0, 8'h0f, 8'hff};
        rows[4] = '{4'h5, 4, 5'h10, 0, 8'h0f, 8'hff};
        rows[5] = '{4'h3, 0, 5'h00, 0, 8'h00, 8'h07};
        rows[6] = '{4'h0, 1, 5'h02, 8, 8'h50, 8'hff};
        do_reset();
        cfg();
        foreach (rows[r]) begin
            clr <= 1'b1;
            dir_cfg <= rows[r].dir;
            @(posedge pclk);
            clr <= 1'b0;
            apb(1'b1, {4'h0, OFF_CTRL}, 32'(rows[r].ctrl));
            apb(1'b1, {4'h0, OFF_DIR}, 32'(rows[r].dir));
            apb(1'b1, {4'h0, OFF_START}, 32'h1 << (rows[r].ax + rows[r].sh));
            wait_done(rows[r].ax);
            chk(32'(homing_busy[rows[r].ax]), 32'h0);
            chk(32'(pos[rows[r].ax] & rows[r].mk), 32'(rows[r].ex));
            apb(1'b0, {4'h0, OFF_STATUS}, 32'h0);
            chk(32'(rd[rows[r].ax]), 32'h1);
            $display("row %0d finished", r);
        end
        apb(1'b1, {4'h0, OFF_START}, 32'h4);
        repeat (40) @(posedge pclk);
        chk(32'(homing_busy[2]), 32'h1);
        do_reset();
        chk(32'({home_done, homing_busy}), 32'h0);
        rc({4'h0, OFF_CTRL}, 32'h0, 1'b0);
        rc({4'h0, OFF_CREEP}, 32'h28, 1'b0);
        rc({4'h0, OFF_RAMP_S}, 32'h0, 1'b0);
        rc(12'h030, 32'h0fa0, 1'b0);
        rc(12'h040, 32'h01f4, 1'b0);
        rc(12'h034, 32'h0, 1'b1);
        rc(12'h100, 32'h0, 1'b1);
        $display("reset test finished");
        apb(1'b1, {4'h0, OFF_CTRL}, 32'h8);
        apb(1'b1, {4'h0, OFF_START}, 32'h800);
        repeat (8) @(posedge pclk);
        chk(32'(homing_busy), 32'h0);
        cfg();
        apb(1'b1, {4'h0, OFF_CTRL}, 32'h0);
        apb(1'b1, {4'h0, OFF_DIR}, 32'(dir_cfg));
        apb(1'b1, {4'h0, OFF_START}, 32'h3);
        repeat (40) @(posedge pclk);
        apb(1'b1, {4'h0, OFF_START}, 32'h1_0000);
        repeat (4) @(posedge pclk);
        chk(32'(homing_busy[1:0]), 32'h2);
        chk(32'(home_done[0]), 32'h0);
        wait_done(1);
        chk(32'(pos[1]), 32'h50);
        $display("abort test finished");
        test_done();
    end
endmodule : tb
`default_nettype wire
